// *** pkg/pfl_pkg.sv ***
package pfl_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_GEN = 4;
	localparam int CNT_W   = 16;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [11:0] OFS_OUTPUT_ENABLE_REG = 12'h000;
	localparam logic [11:0] OFS_IRQ_STATUS_CLEAR  = 12'h004;
	localparam logic [11:0] OFS_FAULT_STATE       = 12'h008;
	localparam logic [11:0] OFS_GEN_CTRL_BASE     = 12'h040;
	localparam logic [11:0] OFS_MIN_FLT_BASE      = 12'h080;
	localparam logic [11:0] OFS_PERIOD_BASE       = 12'h0C0;
	localparam logic [11:0] OFS_DUTY_BASE         = 12'h100;

	// ****************************************
	// generator_control fields
	// ****************************************
	localparam int CTL_RUN_BIT   = 0;
	localparam int CTL_LATCH_BIT = 1;
	localparam int CTL_FPOL_BIT  = 2; // level driven while faulted
	localparam int CTL_W         = 3;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [NUM_GEN-1:0] RST_OUTPUT_ENABLE = 4'h0;
	localparam logic [CTL_W-1:0]   RST_GEN_CTRL      = 3'h0;
	localparam logic [CNT_W-1:0]   RST_MIN_FLT       = 16'h0000;
	localparam logic [CNT_W-1:0]   RST_PERIOD        = 16'h00FF;
	localparam logic [CNT_W-1:0]   RST_DUTY          = 16'h0080;

	// ****************************************
	// bus encodings
	// ****************************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	// fault tracker states, gray along idle->active->hold
	typedef enum logic [1:0] {
		PFL_IDLE   = 2'b00,
		PFL_ACTIVE = 2'b01,
		PFL_HOLD   = 2'b11
	} pfl_fstate_t;

endpackage

// *** rtl/pfl_fault_track.sv ***
`timescale 1ns/1ns
// per-generator fault tracking: minimum period and optional hold
module pfl_fault_track
	import pfl_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             fault_in,
	input  wire logic             latch_en,
	input  wire logic [CNT_W-1:0] min_period,
	input  wire logic             status_clr,
	output logic                  fault_active,
	output logic                  fault_event
);
	pfl_fstate_t      state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic             clr_seen_q, clr_seen_d;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_d     = state_q;
		cnt_d       = cnt_q;
		clr_seen_d  = clr_seen_q;
		fault_event = 1'b0;
		case (state_q)
			PFL_IDLE: begin
				if (fault_in) begin
					state_d     = PFL_ACTIVE;
					cnt_d       = min_period;
					clr_seen_d  = 1'b0;
					fault_event = 1'b1;
				end
			end
			PFL_ACTIVE: begin
				// a clear while still active already ends the hold, no second clear needed
				if (status_clr) begin
					clr_seen_d = 1'b1; // RULE_01
				end
				// min period runs even after input drops
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1; // RULE_03
				end else if (!fault_in) begin
					if (latch_en && !clr_seen_d) begin
						state_d = PFL_HOLD; // RULE_01
					end else begin
						state_d = PFL_IDLE; // RULE_06
					end
				end
			end
			PFL_HOLD: begin
				// held until software clears the status bit or the hold bit is dropped
				if (status_clr || !latch_en) begin
					state_d    = fault_in ? PFL_ACTIVE : PFL_IDLE; // RULE_01
					clr_seen_d = status_clr;
				end
			end
			default: state_d = PFL_IDLE;
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q    <= PFL_IDLE;
			cnt_q      <= '0;
			clr_seen_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			clr_seen_q <= clr_seen_d;
		end
	end

	assign fault_active = (state_q != PFL_IDLE);
endmodule

// *** rtl/pfl_wave_gen.sv ***
`timescale 1ns/1ns
// simple up-counting edge-aligned waveform source
module pfl_wave_gen
	import pfl_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] period,
	input  wire logic [CNT_W-1:0] duty,
	output logic                  wave
);
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic             wave_q, wave_d;

	// ****************************************
	// counter and compare
	// ****************************************
	always_comb begin
		cnt_d  = '0;
		wave_d = 1'b0;
		if (run) begin
			cnt_d  = (cnt_q >= period) ? '0 : cnt_q + 1'b1;
			wave_d = (cnt_d < duty);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q  <= '0;
			wave_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			wave_q <= wave_d;
		end
	end

	assign wave = wave_q;
endmodule

// *** rtl/pfl_top.sv ***
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Functional notes
// [RULE_01] With fault hold set, a generator stays faulted until software clears its status bit.
// [RULE_02] Writing one to a fault status bit clears it, writing zero leaves it alone.
// [RULE_03] A detected fault stays active for at least the programmed minimum fault period.
// [RULE_04] A cleared output enable bit forces the output to zero, not to the fault level.
// [RULE_05] Setting the output enable bit again resumes the programmed waveform.
// [RULE_06] With fault hold clear, the output returns to its waveform once the fault goes away.
module pfl_top
	import pfl_pkg::*;
(
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	input  wire logic [pfl_pkg::NUM_GEN-1:0] fault_pin,
	output logic      [pfl_pkg::NUM_GEN-1:0] pwm_out
);
	import pfl_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	// address match of a per-generator register inside a 4-word bank
	function automatic logic bank_hit(input logic [11:0] a, input logic [11:0] base,
		input int g);
		return a == (base + 12'(g * 4));
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [NUM_GEN-1:0] sync1_q, sync2_q;
	logic [NUM_GEN-1:0] oe_q, oe_d;
	logic [NUM_GEN-1:0] irq_q, irq_d;
	logic [CTL_W-1:0]   ctl_q [NUM_GEN];
	logic [CTL_W-1:0]   ctl_d [NUM_GEN];
	logic [CNT_W-1:0]   mfp_q [NUM_GEN];
	logic [CNT_W-1:0]   mfp_d [NUM_GEN];
	logic [CNT_W-1:0]   per_q [NUM_GEN];
	logic [CNT_W-1:0]   per_d [NUM_GEN];
	logic [CNT_W-1:0]   dut_q [NUM_GEN];
	logic [CNT_W-1:0]   dut_d [NUM_GEN];
	logic [NUM_GEN-1:0] out_q, out_d;
	logic [NUM_GEN-1:0] flt_act;
	logic [NUM_GEN-1:0] flt_evt;
	logic [NUM_GEN-1:0] wave;
	logic [NUM_GEN-1:0] clr_pulse;
	logic               wr_pend_q, wr_pend_d;
	logic [11:0]        wr_addr_q, wr_addr_d;
	logic [31:0]        rdata_q, rdata_d;
	logic               addr_ok;
	logic [31:0]        rd_mux;

	// ****************************************
	// fault pin synchroniser
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= fault_pin;
			sync2_q <= sync1_q;
		end
	end

	// ****************************************
	// per-generator datapath
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NUM_GEN; g++) begin : gen_ch
			pfl_fault_track u_track (
				.hclk         (hclk),
				.hresetn      (hresetn),
				.fault_in     (sync2_q[g]),
				.latch_en     (ctl_q[g][CTL_LATCH_BIT]),
				.min_period   (mfp_q[g]),
				.status_clr   (clr_pulse[g]),
				.fault_active (flt_act[g]),
				.fault_event  (flt_evt[g])
			);
			pfl_wave_gen u_wave (
				.hclk    (hclk),
				.hresetn (hresetn),
				.run     (ctl_q[g][CTL_RUN_BIT]),
				.period  (per_q[g]),
				.duty    (dut_q[g]),
				.wave    (wave[g])
			);
		end
	endgenerate

	// ****************************************
	// output selection
	// ****************************************
	// enable wins over fault: a disabled output is plain zero
	always_comb begin
		for (int i = 0; i < NUM_GEN; i++) begin
			if (!oe_q[i]) begin
				out_d[i] = 1'b0; // RULE_04
			end else if (flt_act[i]) begin
				out_d[i] = ctl_q[i][CTL_FPOL_BIT];
			end else begin
				out_d[i] = wave[i]; // RULE_05
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_q <= '0;
		end else begin
			out_q <= out_d;
		end
	end

	assign pwm_out = out_q;

	// ****************************************
	// bus decode
	// ****************************************
	// address phase is always accepted, zero wait states
	logic addr_take;
	assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

	always_comb begin
		addr_ok = (haddr[11:0] == OFS_OUTPUT_ENABLE_REG) ||
			(haddr[11:0] == OFS_IRQ_STATUS_CLEAR) || (haddr[11:0] == OFS_FAULT_STATE);
		for (int i = 0; i < NUM_GEN; i++) begin
			if (bank_hit(haddr[11:0], OFS_GEN_CTRL_BASE, i) ||
				bank_hit(haddr[11:0], OFS_MIN_FLT_BASE, i) ||
				bank_hit(haddr[11:0], OFS_PERIOD_BASE, i) ||
				bank_hit(haddr[11:0], OFS_DUTY_BASE, i)) begin
				addr_ok = 1'b1;
			end
		end
	end

	// read mux on the address phase; unmapped reads zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[11:0] == OFS_OUTPUT_ENABLE_REG) rd_mux[NUM_GEN-1:0] = oe_q;
		if (haddr[11:0] == OFS_IRQ_STATUS_CLEAR)  rd_mux[NUM_GEN-1:0] = irq_q;
		if (haddr[11:0] == OFS_FAULT_STATE)       rd_mux[NUM_GEN-1:0] = flt_act;
		for (int i = 0; i < NUM_GEN; i++) begin
			if (bank_hit(haddr[11:0], OFS_GEN_CTRL_BASE, i)) rd_mux[CTL_W-1:0] = ctl_q[i];
			if (bank_hit(haddr[11:0], OFS_MIN_FLT_BASE, i))  rd_mux[CNT_W-1:0] = mfp_q[i];
			if (bank_hit(haddr[11:0], OFS_PERIOD_BASE, i))   rd_mux[CNT_W-1:0] = per_q[i];
			if (bank_hit(haddr[11:0], OFS_DUTY_BASE, i))     rd_mux[CNT_W-1:0] = dut_q[i];
		end
	end

	always_comb begin
		wr_pend_d = addr_take && hwrite && addr_ok;
		wr_addr_d = addr_take ? haddr[11:0] : wr_addr_q;
		rdata_d   = (addr_take && !hwrite) ? rd_mux : rdata_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			rdata_q   <= '0;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q   <= rdata_d;
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ****************************************
	// register writes (data phase)
	// ****************************************
	always_comb begin
		oe_d      = oe_q;
		clr_pulse = '0;
		if (wr_pend_q && wr_addr_q == OFS_OUTPUT_ENABLE_REG) begin
			oe_d = hwdata[NUM_GEN-1:0]; // RULE_04 RULE_05
		end
		if (wr_pend_q && wr_addr_q == OFS_IRQ_STATUS_CLEAR) begin
			clr_pulse = hwdata[NUM_GEN-1:0]; // RULE_02
		end
		// a new fault in the clearing cycle keeps the bit set
		irq_d = (irq_q & ~clr_pulse) | flt_evt; // RULE_02
		for (int i = 0; i < NUM_GEN; i++) begin
			ctl_d[i] = ctl_q[i];
			mfp_d[i] = mfp_q[i];
			per_d[i] = per_q[i];
			dut_d[i] = dut_q[i];
			if (wr_pend_q && bank_hit(wr_addr_q, OFS_GEN_CTRL_BASE, i))
				ctl_d[i] = hwdata[CTL_W-1:0];
			if (wr_pend_q && bank_hit(wr_addr_q, OFS_MIN_FLT_BASE, i))
				mfp_d[i] = hwdata[CNT_W-1:0]; // RULE_03
			if (wr_pend_q && bank_hit(wr_addr_q, OFS_PERIOD_BASE, i))
				per_d[i] = hwdata[CNT_W-1:0];
			if (wr_pend_q && bank_hit(wr_addr_q, OFS_DUTY_BASE, i))
				dut_d[i] = hwdata[CNT_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			oe_q  <= RST_OUTPUT_ENABLE;
			irq_q <= '0;
			for (int i = 0; i < NUM_GEN; i++) begin
				ctl_q[i] <= RST_GEN_CTRL;
				mfp_q[i] <= RST_MIN_FLT;
				per_q[i] <= RST_PERIOD;
				dut_q[i] <= RST_DUTY;
			end
		end else begin
			oe_q  <= oe_d;
			irq_q <= irq_d;
			for (int i = 0; i < NUM_GEN; i++) begin
				ctl_q[i] <= ctl_d[i];
				mfp_q[i] <= mfp_d[i];
				per_q[i] <= per_d[i];
				dut_q[i] <= dut_d[i];
			end
		end
	end
endmodule

// *** dv/pfl_top_monitor.sv ***
`timescale 1ns/1ns
// ********
// port checker
// ********
module pfl_top_monitor (
	input wire logic                        hclk,
	input wire logic                        hresetn,
	input wire logic                        hsel,
	input wire logic [31:0]                 haddr,
	input wire logic [1:0]                  htrans,
	input wire logic                        hwrite,
	input wire logic [31:0]                 hwdata,
	input wire logic                        hready,
	input wire logic [31:0]                 hrdata,
	input wire logic                        hreadyout,
	input wire logic                        hresp,
	input wire logic [pfl_pkg::NUM_GEN-1:0] fault_pin,
	input wire logic [pfl_pkg::NUM_GEN-1:0] pwm_out
);
	import pfl_pkg::*;
	logic [11:0]        adr_q, adr_d;
	logic               wr_q, wr_d;
	logic [NUM_GEN-1:0] en_q, en_d;
	logic [CTL_W-1:0]   ctl_q, ctl_d;
	wire                rd_take = hsel && hready && htrans[1] && !hwrite;
	// shadow only the enable register and the control of generator 0, enough for the checks
	always_comb begin
		adr_d = haddr[11:0];
		wr_d = hsel && hready && htrans[1] && hwrite;
		en_d = en_q;
		ctl_d = ctl_q;
		if (wr_q && adr_q == OFS_OUTPUT_ENABLE_REG) en_d = hwdata[NUM_GEN-1:0];
		if (wr_q && adr_q == OFS_GEN_CTRL_BASE) ctl_d = hwdata[CTL_W-1:0];
	end
	// shadow registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adr_q <= 12'h000;
			wr_q <= 1'b0;
			en_q <= RST_OUTPUT_ENABLE;
			ctl_q <= RST_GEN_CTRL;
		end else begin
			adr_q <= adr_d;
			wr_q <= wr_d;
			en_q <= en_d;
			ctl_q <= ctl_d;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout) else $error("ready low");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_rdata_hold: assert property (!rd_take |=> $stable(hrdata)) else $error("rdata moved");
	a_unmapped_zero: assert property (rd_take && haddr[11:0] == 12'h03C |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_enable_back: assert property (
		rd_take && haddr[11:0] == OFS_OUTPUT_ENABLE_REG && !wr_q |=> hrdata == 32'($past(en_q)))
		else $error("enable readback wrong");
	a_off_forces_low: assert property (
		(~en_q & ~$past(en_q) & ~$past(en_q, 2) & pwm_out) == 4'h0) else $error("disabled out high");
	a_fault_level: assert property (
		(fault_pin[0] && en_q[0] && ctl_q[0] && $stable(ctl_q))[*6] |-> pwm_out[0] == ctl_q[2])
		else $error("fault level wrong");
	a_fault_flagged: assert property (
		fault_pin[0][*6] ##0 (rd_take && haddr[11:0] == OFS_FAULT_STATE) |=> hrdata[0])
		else $error("fault state clear");
	c_unmapped: cover property (rd_take && haddr[11:0] == 12'h03C);
	c_fault_on: cover property ((fault_pin[0] && en_q[0])[*6]);
	c_disable: cover property ($fell(en_q[0]));
endmodule
bind pfl_top pfl_top_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .fault_pin, .pwm_out);

// *** dv/pfl_fault_src.sv ***
`timescale 1ns/1ns
// ********
// external fault source
// ********
module pfl_fault_src (
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic [pfl_pkg::NUM_GEN-1:0] trip,
	output logic      [pfl_pkg::NUM_GEN-1:0] fault_pin
);
	import pfl_pkg::*;
	logic [NUM_GEN-1:0] pin_q, pin_d;
	// sensor answers one cycle late, never glitch-free by luck
	always_comb begin
		pin_d = trip;
	end
	// comparator output register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) pin_q <= '0;
		else pin_q <= pin_d;
	end
	assign fault_pin = pin_q;
endmodule

// *** dv/pfl_top_tb.sv ***
`timescale 1ns/1ns
// ********
// bench
// ********
module pfl_top_tb;
	import pfl_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp;
	logic [3:0]  trip = 0, fault_pin, pwm_out;
	int          fail_count = 0, checks_done = 0, seed = 42, m;
	always #25 hclk = ~hclk;
	pfl_fault_src u_src (.hclk, .hresetn, .trip, .fault_pin);
	pfl_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .fault_pin, .pwm_out);
	task conclude();
		if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// the slave's latency is not assumed, only bounded
	task wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) begin
			chk("hready", 0, 1);
			conclude();
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task wait_out(input int g, input logic v, input int lim);
		int n;
		n = 0;
		#1;
		while (pwm_out[g] !== v && n < lim) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk("pwm_out", pwm_out[g], v);
		if (pwm_out[g] !== v) conclude();
	endtask
	function logic [31:0] bitg(input int g);
		return 32'h1 << g;
	endfunction
	initial begin
		repeat (50000) @(posedge hclk);
		chk("timeout", 0, 1);
		conclude();
	end
	// reset values, then per-generator fault sequences
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, OFS_OUTPUT_ENABLE_REG, 0);
		chk("enable", rd, 32'(RST_OUTPUT_ENABLE));
		bus(1, 12'h03C, 32'hFFFFFFFF);
		bus(0, 12'h03C, 0);
		chk("unmapped", rd, 0);
		for (int g = 0; g < NUM_GEN; g++) begin
			bus(0, OFS_PERIOD_BASE + 12'(4 * g), 0);
			chk("period", rd, 32'(RST_PERIOD));
			bus(0, OFS_DUTY_BASE + 12'(4 * g), 0);
			chk("duty", rd, 32'(RST_DUTY));
			bus(0, OFS_MIN_FLT_BASE + 12'(4 * g), 0);
			chk("min", rd, 32'(RST_MIN_FLT));
			m = 1 + ($unsigned($random(seed)) % 8);
			bus(1, OFS_PERIOD_BASE + 12'(4 * g), 32'(8 + $unsigned($random(seed)) % 8));
			bus(1, OFS_DUTY_BASE + 12'(4 * g), 32'hFFFF);
			bus(1, OFS_MIN_FLT_BASE + 12'(4 * g), m);
			bus(1, OFS_GEN_CTRL_BASE + 12'(4 * g), 32'(g % 2 * 2 + 1));
			bus(1, OFS_OUTPUT_ENABLE_REG, 32'hF);
			wait_out(g, 1, 40);
			trip[g] <= 1'b1;
			@(posedge hclk);
			trip[g] <= 1'b0;
			wait_out(g, 0, 10);
			repeat (m) begin
				@(posedge hclk);
				#1;
				chk("min period", pwm_out[g], 0);
			end
			if (g % 2 == 1) begin
				repeat (20) @(posedge hclk);
				bus(0, OFS_IRQ_STATUS_CLEAR, 0);
				chk("status", rd & bitg(g), bitg(g));
				bus(1, OFS_IRQ_STATUS_CLEAR, ~bitg(g));
				bus(0, OFS_IRQ_STATUS_CLEAR, 0);
				chk("status kept", rd & bitg(g), bitg(g));
				chk("held", pwm_out[g], 0);
				bus(1, OFS_IRQ_STATUS_CLEAR, bitg(g));
				bus(0, OFS_IRQ_STATUS_CLEAR, 0);
				chk("status clr", rd & bitg(g), 0);
				wait_out(g, 1, 10);
				// clear while the pin still stands: no second clear needed
				trip[g] <= 1'b1;
				wait_out(g, 0, 10);
				bus(1, OFS_IRQ_STATUS_CLEAR, bitg(g));
				trip[g] <= 1'b0;
				wait_out(g, 1, 20);
				bus(0, OFS_IRQ_STATUS_CLEAR, 0);
				chk("status early clr", rd & bitg(g), 0);
				// dropping the hold bit releases a held fault
				trip[g] <= 1'b1;
				@(posedge hclk);
				trip[g] <= 1'b0;
				repeat (24) @(posedge hclk);
				chk("held again", pwm_out[g], 0);
				bus(1, OFS_GEN_CTRL_BASE + 12'(4 * g), 1);
				wait_out(g, 1, 10);
			end else begin
				wait_out(g, 1, 10);
			end
			// low waveform, high fault level: disable must win with zero
			bus(1, OFS_DUTY_BASE + 12'(4 * g), 0);
			bus(1, OFS_GEN_CTRL_BASE + 12'(4 * g), 32'h5);
			trip[g] <= 1'b1;
			wait_out(g, 1, 10);
			bus(0, OFS_FAULT_STATE, 0);
			chk("fault state", rd & bitg(g), bitg(g));
			bus(1, OFS_OUTPUT_ENABLE_REG, ~bitg(g) & 32'hF);
			wait_out(g, 0, 5);
			trip[g] <= 1'b0;
			bus(1, OFS_DUTY_BASE + 12'(4 * g), 32'hFFFF);
			bus(1, OFS_OUTPUT_ENABLE_REG, 32'hF);
			wait_out(g, 1, 40);
		end
		conclude();
	end
endmodule
